// [diag_cfg.svh]
// Offsets, field positions, reset values and timing counts of the diagnostic block
// Behaviour
// [R1] Fast oscillator outside 15..17 MHz sets flag
// [R2] Selector 1h temperature source, 2h supply check
// [R3] Selector 3h alternate reference, 4h comparator path
// [R4] Selectors 5h, 6h, 9h run calibration checks
// [R5] Selectors 7h, 8h drive DAC 1772/591
// [R6] Selectors Ah, Bh zero and full scale
// [R7] Selector Ch measures level-shift amplifier offset
// [R8] Scan 4h..7h sets balance alerts and summary
// [R9] Headroom flag refreshed only during measurement
// [R10] Accuracy flags updated after oversampled acquisition
// [R11] Receive port mode checked once after reset
// [R12] Flex pack fault checked continuously
// [R13] Short test in UART mode needs the enable bit
// [R14] Test drives pin low on alert, else high
// [R15] Short test ignores serial configuration mode
// [R16] SPI mode uses drive-init bit instead
// [R17] Host sets open select and comparator scan
// [R18] Open test flags cells below threshold
// [R19] Bipolar cells skipped, flag stays clear
// [R20] Host enables test currents and level
// [R21] Temperature result stored in bits 15:2
// [R22] Temperature conversion waits 39 us settling
// [R23] Die temperature monitor paused while requested
// [R24] Selectors independent; zero runs nothing
`ifndef DIAG_CFG_SVH
`define DIAG_CFG_SVH
`define CTRL_OFS 8'h00
`define CMD_OFS 8'h04
`define THRESH_OFS 8'h08
`define CELLCFG_OFS 8'h0c
`define SECOND_STATUS_REG_OFS 8'h10
`define FAULT1_OFS 8'h14
`define RESULT_A_OFS 8'h18
`define RESULT_B_OFS 8'h1c
`define COMP_ALERT_OFS 8'h20
`define BAL_ALERT_OFS 8'h24
`define CTRL_WIDTH 22
`define CTRL_RESET 22'h000000
`define THRESH_RESET 10'h000
`define FAST_OSC_BIT 5
`define F1_HDRM_BIT 0
`define F1_BALSUM_BIT 1
`define F1_FLEX_BIT 2
`define F1_ACCOV_BIT 3
`define F1_ACCUV_BIT 4
`define F1_PORTU_BIT 5
`define F1_PORTL_BIT 6
`define CTRL_CELLS_BIT 16
`define SEL_NONE 4'h0
`define SEL_TEMP 4'h1
`define SCAN_COMP 3'h2
`define FAST_OSC_MIN_KHZ 16'd15000
`define FAST_OSC_MAX_KHZ 16'd17000
`define CLK_PERIOD_NS 50
`define DIE_SETTLE_NS 39000
`endif

// [diag_pkg.sv]
// Types shared by the diagnostic control block
package diag_pkg;
    typedef logic [3:0] sel_t;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_SETTLE = 3'b001,
        SEQ_CONV_A = 3'b010,
        SEQ_CONV_B = 3'b011,
        SEQ_FIN = 3'b100
    } seq_e;
    typedef struct packed {
        logic [3:0] testCurrentLevel;
        logic [1:0] serialConfigMode;
        logic interfaceSelect;
        logic spiDriveInitBit;
        logic userAlertBit;
        logic alertShortTestEnable;
        logic openDiagSelect;
        logic [2:0] scanConfigField;
        sel_t diagSelectorB;
        sel_t diagSelectorA;
    } ctrl_s;
    typedef struct packed {
        logic valid;
        logic [3:0] idx;
        logic [9:0] data;
    } comp_s;
endpackage

// [built_in_diagnostic_control.sv]
// Diagnostic selection, fault flags and alert pin test with a Wishbone register slave
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`include "diag_cfg.svh"
module built_in_diagnostic_control #(
    parameter int NUM_CELLS = 14
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] oscKhz,
    input wire logic oscKhzValid,
    input wire logic convDone,
    input wire logic [13:0] convData,
    output logic convReq,
    output diag_pkg::sel_t convSel,
    output logic measActive,
    output diag_pkg::ctrl_s ctrlOut,
    output logic [NUM_CELLS-1:0] testCurrentEn,
    output logic dieTempMonitorEn,
    input wire diag_pkg::comp_s compIn,
    input wire logic balSwValid,
    input wire logic [NUM_CELLS-1:0] balSwFault,
    input wire logic hvHeadroomLow,
    input wire logic oversampleDone,
    input wire logic accOverIn,
    input wire logic accUnderIn,
    input wire logic rxUpperOk,
    input wire logic rxLowerOk,
    input wire logic flexPackFaultIn,
    input wire logic alertPresent,
    output logic alert_output_pin,
    output logic alertOutEn
);
    import diag_pkg::*;

    localparam int SETTLE_CYC = (`DIE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int CW = $clog2(SETTLE_CYC + 1);

    // Reject cell counts the register layout cannot hold
    if (NUM_CELLS < 1 || NUM_CELLS > 16) begin : g_bad_cells
        $error("NUM_CELLS must be 1 to 16");
    end

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Address compare alone; the live write cycle is qualified through wmask
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction

    ctrl_s ctrl_ff, nxt_ctrl_ff;
    logic [9:0] thresh_ff, nxt_thresh_ff;
    logic [NUM_CELLS-1:0] bipolar_ff, nxt_bipolar_ff;
    logic [NUM_CELLS-1:0] tstEn_ff, nxt_tstEn_ff;
    logic ack_ff, nxt_ack_ff;
    logic [31:0] rdat_ff, nxt_rdat_ff;
    logic fastOsc_ff, nxt_fastOsc_ff;
    logic [6:0] fault1_ff, nxt_fault1_ff;
    logic [NUM_CELLS-1:0] compAlert_ff, nxt_compAlert_ff;
    logic [NUM_CELLS-1:0] balAlert_ff, nxt_balAlert_ff;
    logic portChecked_ff, nxt_portChecked_ff;
    logic alert_output_pin_ff, nxt_alert_output_pin_ff;
    logic alertOutEn_ff, nxt_alertOutEn_ff;
    logic tempMon_ff, nxt_tempMon_ff;
    seq_e state_ff, nxt_state_ff;
    logic [CW-1:0] cnt_ff, nxt_cnt_ff;
    logic convReq_ff, nxt_convReq_ff;
    sel_t convSel_ff, nxt_convSel_ff;
    logic measAct_ff, nxt_measAct_ff;
    logic [15:0] resA_ff, nxt_resA_ff;
    logic [15:0] resB_ff, nxt_resB_ff;
    logic [NUM_CELLS-1:0] openHit;
    logic [31:0] wmask, wclr;
    logic wrStb, startWr, needTemp, anyAlert, testMode;

    // Open-cell comparison, one lane per cell
    genvar gi;
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_open
        // [R18] below threshold flags
        // [R19] bipolar cells skipped
        assign openHit[gi] = compIn.valid && (compIn.idx == 4'(gi)) && ctrl_ff.openDiagSelect
            && (ctrl_ff.scanConfigField == `SCAN_COMP) && !bipolar_ff[gi]
            && (compIn.data < thresh_ff);
    end

    // Bus decode helpers
    // Writes take effect at the edge where the master samples ack
    assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
    assign wmask = wrStb ? laneMask(wb_sel_i) : 32'h00000000;
    assign wclr = wb_dat_i & wmask;
    assign startWr = hit(wb_adr_i, `CMD_OFS) && wclr[0] && (state_ff == SEQ_IDLE);
    // [R23] temperature request
    assign needTemp = (ctrl_ff.diagSelectorA == `SEL_TEMP) || (ctrl_ff.diagSelectorB == `SEL_TEMP);
    // [R15] serial config mode not used
    assign testMode = ctrl_ff.interfaceSelect ? ctrl_ff.alertShortTestEnable
                                              : ctrl_ff.spiDriveInitBit;
    assign anyAlert = alertPresent || ctrl_ff.userAlertBit || fastOsc_ff || (|fault1_ff)
        || (|compAlert_ff) || (|balAlert_ff);

    // Register file, bus answer and read mux
    always_comb begin
        nxt_ctrl_ff = ctrl_ff;
        nxt_thresh_ff = thresh_ff;
        nxt_bipolar_ff = bipolar_ff;
        nxt_tstEn_ff = tstEn_ff;
        nxt_ack_ff = wb_cyc_i && wb_stb_i && !ack_ff;
        nxt_rdat_ff = 32'h00000000;
        if (hit(wb_adr_i, `CTRL_OFS)) begin
            nxt_ctrl_ff = ctrl_s'(22'((32'(ctrl_ff) & ~wmask) | (wb_dat_i & wmask)));
        end
        if (hit(wb_adr_i, `THRESH_OFS)) begin
            nxt_thresh_ff = (thresh_ff & ~wmask[9:0]) | (wb_dat_i[9:0] & wmask[9:0]);
        end
        if (hit(wb_adr_i, `CELLCFG_OFS)) begin
            nxt_bipolar_ff = (bipolar_ff & ~wmask[NUM_CELLS-1:0])
                | (wb_dat_i[NUM_CELLS-1:0] & wmask[NUM_CELLS-1:0]);
            // [R20] host test current enables
            nxt_tstEn_ff = (tstEn_ff & ~wmask[`CTRL_CELLS_BIT +: NUM_CELLS])
                | (wb_dat_i[`CTRL_CELLS_BIT +: NUM_CELLS] & wmask[`CTRL_CELLS_BIT +: NUM_CELLS]);
        end
        case (wb_adr_i)
            `CTRL_OFS: nxt_rdat_ff = 32'(ctrl_ff);
            `CMD_OFS: nxt_rdat_ff = 32'(state_ff != SEQ_IDLE);
            `THRESH_OFS: nxt_rdat_ff = 32'(thresh_ff);
            `CELLCFG_OFS: nxt_rdat_ff = 32'(bipolar_ff) | (32'(tstEn_ff) << `CTRL_CELLS_BIT);
            `SECOND_STATUS_REG_OFS: nxt_rdat_ff = 32'(fastOsc_ff) << `FAST_OSC_BIT;
            `FAULT1_OFS: nxt_rdat_ff = 32'(fault1_ff);
            `RESULT_A_OFS: nxt_rdat_ff = 32'(resA_ff);
            `RESULT_B_OFS: nxt_rdat_ff = 32'(resB_ff);
            `COMP_ALERT_OFS: nxt_rdat_ff = 32'(compAlert_ff);
            `BAL_ALERT_OFS: nxt_rdat_ff = 32'(balAlert_ff);
            default: nxt_rdat_ff = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= ctrl_s'(`CTRL_RESET);
            thresh_ff <= `THRESH_RESET;
            bipolar_ff <= '0;
            tstEn_ff <= '0;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end else begin
            ctrl_ff <= nxt_ctrl_ff;
            thresh_ff <= nxt_thresh_ff;
            bipolar_ff <= nxt_bipolar_ff;
            tstEn_ff <= nxt_tstEn_ff;
            ack_ff <= nxt_ack_ff;
            rdat_ff <= nxt_rdat_ff;
        end
    end

    // Sticky fault flags; a set in the clearing cycle wins
    always_comb begin
        nxt_fastOsc_ff = fastOsc_ff;
        nxt_fault1_ff = fault1_ff;
        nxt_compAlert_ff = compAlert_ff;
        nxt_balAlert_ff = balAlert_ff;
        nxt_portChecked_ff = 1'b1;
        if (hit(wb_adr_i, `SECOND_STATUS_REG_OFS)) begin
            nxt_fastOsc_ff = fastOsc_ff & ~wclr[`FAST_OSC_BIT];
        end
        if (hit(wb_adr_i, `FAULT1_OFS)) begin
            nxt_fault1_ff = fault1_ff & ~wclr[6:0];
        end
        if (hit(wb_adr_i, `COMP_ALERT_OFS)) begin
            nxt_compAlert_ff = compAlert_ff & ~wclr[NUM_CELLS-1:0];
        end
        if (hit(wb_adr_i, `BAL_ALERT_OFS)) begin
            nxt_balAlert_ff = balAlert_ff & ~wclr[NUM_CELLS-1:0];
        end
        // [R1] oscillator window
        if (oscKhzValid && (oscKhz < `FAST_OSC_MIN_KHZ || oscKhz > `FAST_OSC_MAX_KHZ)) begin
            nxt_fastOsc_ff = 1'b1;
        end
        // [R9] headroom during measurement
        if (measActive && hvHeadroomLow) begin
            nxt_fault1_ff[`F1_HDRM_BIT] = 1'b1;
        end
        // [R10] after oversampled acquisition
        if (oversampleDone) begin
            nxt_fault1_ff[`F1_ACCOV_BIT] = fault1_ff[`F1_ACCOV_BIT] | accOverIn;
            nxt_fault1_ff[`F1_ACCUV_BIT] = fault1_ff[`F1_ACCUV_BIT] | accUnderIn;
        end
        // [R12] continuous flex pack check
        if (flexPackFaultIn) begin
            nxt_fault1_ff[`F1_FLEX_BIT] = 1'b1;
        end
        // [R11] receive mode after reset
        if (!portChecked_ff) begin
            nxt_fault1_ff[`F1_PORTU_BIT] = !rxUpperOk;
            nxt_fault1_ff[`F1_PORTL_BIT] = !rxLowerOk;
        end
        // [R8] balancing switch scans
        if (balSwValid && ctrl_ff.scanConfigField[2]) begin
            nxt_balAlert_ff = nxt_balAlert_ff | balSwFault;
            nxt_fault1_ff[`F1_BALSUM_BIT] = nxt_fault1_ff[`F1_BALSUM_BIT] | (|balSwFault);
        end
        nxt_compAlert_ff = nxt_compAlert_ff | openHit;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fastOsc_ff <= 1'b0;
            fault1_ff <= 7'h00;
            compAlert_ff <= '0;
            balAlert_ff <= '0;
            portChecked_ff <= 1'b0;
        end else begin
            fastOsc_ff <= nxt_fastOsc_ff;
            fault1_ff <= nxt_fault1_ff;
            compAlert_ff <= nxt_compAlert_ff;
            balAlert_ff <= nxt_balAlert_ff;
            portChecked_ff <= nxt_portChecked_ff;
        end
    end

    // Alert pin test and die temperature monitor gate
    always_comb begin
        nxt_alertOutEn_ff = 1'b0;
        nxt_alert_output_pin_ff = 1'b1;
        // [R13] UART enable bit
        // [R16] SPI drive-init bit
        if (testMode) begin
            nxt_alertOutEn_ff = 1'b1;
            // [R14] low on alert
            nxt_alert_output_pin_ff = !anyAlert;
        end
        // [R23] monitor paused
        nxt_tempMon_ff = !needTemp;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            alert_output_pin_ff <= 1'b1;
            alertOutEn_ff <= 1'b0;
            tempMon_ff <= 1'b1;
        end else begin
            alert_output_pin_ff <= nxt_alert_output_pin_ff;
            alertOutEn_ff <= nxt_alertOutEn_ff;
            tempMon_ff <= nxt_tempMon_ff;
        end
    end

    // Acquisition sequencer: settle, then selector A, then selector B
    always_comb begin
        nxt_state_ff = state_ff;
        nxt_cnt_ff = cnt_ff;
        nxt_convReq_ff = convReq_ff;
        nxt_convSel_ff = convSel_ff;
        nxt_resA_ff = resA_ff;
        nxt_resB_ff = resB_ff;
        case (state_ff)
            SEQ_IDLE: begin
                nxt_cnt_ff = '0;
                if (startWr) begin
                    nxt_state_ff = SEQ_SETTLE;
                end
            end
            SEQ_SETTLE: begin
                // [R22] settling before temperature
                if (needTemp && cnt_ff < CW'(SETTLE_CYC)) begin
                    nxt_cnt_ff = cnt_ff + 1'b1;
                end else begin
                    nxt_state_ff = SEQ_CONV_A;
                end
            end
            SEQ_CONV_A: begin
                // [R24] zero selector skipped
                if (ctrl_ff.diagSelectorA == `SEL_NONE) begin
                    nxt_state_ff = SEQ_CONV_B;
                end else if (convReq_ff && convDone) begin
                    // [R21] result in 15:2
                    nxt_resA_ff = {convData, 2'b00};
                    nxt_convReq_ff = 1'b0;
                    nxt_state_ff = SEQ_CONV_B;
                end else begin
                    // [R2] [R3] [R4] [R5] [R6] [R7] selector code to front end
                    nxt_convReq_ff = 1'b1;
                    nxt_convSel_ff = ctrl_ff.diagSelectorA;
                end
            end
            SEQ_CONV_B: begin
                // [R24] independent selector
                if (ctrl_ff.diagSelectorB == `SEL_NONE) begin
                    nxt_state_ff = SEQ_FIN;
                end else if (convReq_ff && convDone) begin
                    nxt_resB_ff = {convData, 2'b00};
                    nxt_convReq_ff = 1'b0;
                    nxt_state_ff = SEQ_FIN;
                end else begin
                    nxt_convReq_ff = 1'b1;
                    nxt_convSel_ff = ctrl_ff.diagSelectorB;
                end
            end
            SEQ_FIN: nxt_state_ff = SEQ_IDLE;
            default: nxt_state_ff = SEQ_IDLE;
        endcase
        // Busy level kept in a flop of its own for the output port
        nxt_measAct_ff = (nxt_state_ff != SEQ_IDLE);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= SEQ_IDLE;
            cnt_ff <= '0;
            convReq_ff <= 1'b0;
            convSel_ff <= `SEL_NONE;
            resA_ff <= 16'h0000;
            resB_ff <= 16'h0000;
            measAct_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state_ff;
            cnt_ff <= nxt_cnt_ff;
            convReq_ff <= nxt_convReq_ff;
            convSel_ff <= nxt_convSel_ff;
            resA_ff <= nxt_resA_ff;
            resB_ff <= nxt_resB_ff;
            measAct_ff <= nxt_measAct_ff;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o = rdat_ff;
    assign wb_ack_o = ack_ff;
    assign convReq = convReq_ff;
    assign convSel = convSel_ff;
    assign measActive = measAct_ff;
    assign ctrlOut = ctrl_ff;
    assign testCurrentEn = tstEn_ff;
    assign dieTempMonitorEn = tempMon_ff;
    assign alert_output_pin = alert_output_pin_ff;
    assign alertOutEn = alertOutEn_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_OSC: assert property (oscKhzValid && oscKhz > `FAST_OSC_MAX_KHZ |=> fastOsc_ff) // [R1]
        else $error("fast oscillator fault not flagged");
    AST_HDRM: assert property ($rose(fault1_ff[`F1_HDRM_BIT]) |-> // [R9]
        $past(measActive && hvHeadroomLow)) else $error("headroom flag set outside measurement");
    AST_ACC: assert property (oversampleDone && accUnderIn |=> fault1_ff[`F1_ACCUV_BIT]) // [R10]
        else $error("accuracy under flag missed");
    AST_RES: assert property (state_ff == SEQ_CONV_A && convReq_ff && convDone // [R21]
        |=> resA_ff == {$past(convData), 2'b00}) else $error("result A not stored at 15:2");
    AST_SETTLE: assert property (convReq_ff && convSel_ff == `SEL_TEMP // [R22]
        |-> cnt_ff == CW'(SETTLE_CYC)) else $error("temperature converted before settling");
    AST_TMON: assert property (needTemp |=> !dieTempMonitorEn) // [R23]
        else $error("die monitor not paused");
    AST_PIN: assert property (testMode && anyAlert |=> alertOutEn && !alert_output_pin) // [R14]
        else $error("alert pin not driven low");
    AST_SPI: assert property (!ctrl_ff.interfaceSelect && !ctrl_ff.spiDriveInitBit // [R16]
        |=> !alertOutEn) else $error("short test active in SPI mode");
    AST_ACK: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_UART: assert property (ctrl_ff.interfaceSelect && !ctrl_ff.alertShortTestEnable // [R13]
        |=> !alertOutEn) else $error("short test active without enable");
    AST_BAL: assert property (balSwValid && ctrl_ff.scanConfigField[2] && (|balSwFault) // [R8]
        |=> fault1_ff[`F1_BALSUM_BIT]) else $error("balance summary flag missed");
    AST_FLEX: assert property (flexPackFaultIn |=> fault1_ff[`F1_FLEX_BIT]) // [R12]
        else $error("flex pack fault missed");
    AST_PORT: assert property ($rose(fault1_ff[`F1_PORTU_BIT]) |-> // [R11]
        $past(!portChecked_ff)) else $error("port flag set after the reset check");
endmodule

// [diag_afe_model.sv]
// Conversion engine stand-in answering the block's conversion requests
`include "diag_cfg.svh"
module diag_afe_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic convReq,
    input wire diag_pkg::sel_t convSel,
    input wire logic measActive,
    input wire logic slow,
    output logic convDone,
    output logic [13:0] convData,
    output int settle
);
    timeunit 1ns;
    timeprecision 1ns;
    import diag_pkg::*;
    int cnt;
    int run;
    logic fired;
    // Answer one or five cycles after the request is seen; data toggles away from the last value between answers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            convDone <= 1'h0;
            convData <= 14'h0;
            cnt <= 0;
            run <= 0;
            fired <= 1'h0;
            settle <= 0;
        end else begin
            run <= measActive ? run + 1 : 0;
            convDone <= 1'h0;
            convData <= ~convData;
            if (fired || !convReq) begin
                fired <= 1'h0;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
                // Settling seen before a temperature request
                if (cnt == 0 && convSel == `SEL_TEMP) settle <= run;
                if (cnt == (slow ? 5 : 1)) begin
                    convDone <= 1'h1;
                    convData <= {convSel, convSel, convSel, 2'h1} ^ 14'h1234;
                    fired <= 1'h1;
                end
            end
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the diagnostic control block
`include "diag_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failCount++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import diag_pkg::*;
    logic clock = 1'h0, resetn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, chkOn = 1'h0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, wbDatO, expA = 32'h0, expB = 32'h0, e;
    logic wbAck, convReq, measActive, dieTempMonitorEn, alert_output_pin, alertOutEn, convDone;
    logic [15:0] oscKhz = 16'h0;
    logic oscKhzValid = 1'h0, balSwValid = 1'h0, hvHeadroomLow = 1'h0, oversampleDone = 1'h0;
    logic accOverIn = 1'h0, accUnderIn = 1'h0, rxUpperOk = 1'h0, rxLowerOk = 1'h1;
    logic flexPackFaultIn = 1'h0, alertPresent = 1'h0, slow = 1'h0;
    logic [13:0] convData, balSwFault = 14'h0, testCurrentEn, mask;
    logic [15:0] oscSet[3] = '{16'h3a97, 16'h3e80, 16'h4269};
    logic oscHit[3] = '{1'h1, 1'h0, 1'h1};
    logic [9:0] d;
    sel_t convSel, b;
    ctrl_s cv, ctrlO;
    comp_s compIn = '0;
    int settle, failCount = 0, comparisons = 0, cycles = 0;
    logic [31:0] expQ[$];

    built_in_diagnostic_control #(.NUM_CELLS(14)) built_in_diagnostic_control_i (
        .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .oscKhz(oscKhz), .oscKhzValid(oscKhzValid), .convDone(convDone), .convData(convData),
        .convReq(convReq), .convSel(convSel), .measActive(measActive), .ctrlOut(ctrlO),
        .testCurrentEn(testCurrentEn), .dieTempMonitorEn(dieTempMonitorEn), .compIn(compIn),
        .balSwValid(balSwValid), .balSwFault(balSwFault), .hvHeadroomLow(hvHeadroomLow),
        .oversampleDone(oversampleDone), .accOverIn(accOverIn), .accUnderIn(accUnderIn),
        .rxUpperOk(rxUpperOk), .rxLowerOk(rxLowerOk), .flexPackFaultIn(flexPackFaultIn),
        .alertPresent(alertPresent), .alert_output_pin(alert_output_pin), .alertOutEn(alertOutEn));
    diag_afe_model diag_afe_model_i (.clock(clock), .resetn(resetn), .convReq(convReq),
        .convSel(convSel), .measActive(measActive), .slow(slow), .convDone(convDone),
        .convData(convData), .settle(settle));

    initial begin
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] resultOf(input sel_t s);
        return {16'h0, {s, s, s, 2'h1} ^ 14'h1234, 2'h0};
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One classic cycle, held until ack is sampled, then a free cycle
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dv);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        wdat <= dv;
        sel <= 4'hf;
        cyc <= 1'h1;
        stb <= 1'h1;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'h1 && n < 50);
        if (n >= 50) failCount++;
        rdat = wbDatO;
        cyc <= 1'h0;
        stb <= 1'h0;
        chkOn <= 1'h0;
        @(posedge clock);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] ev);
        expQ.push_back(ev);
        chkOn <= 1'h1;
        bus(a, 1'h0, 32'h0);
    endtask

    task automatic wrCtrl();
        bus(`CTRL_OFS, 1'h1, 32'(cv));
        @(posedge clock);
    endtask

    // Read answers are compared with the oldest note; cycle ceiling cuts a hang
    always @(posedge clock) begin
        cycles++;
        if (wbAck === 1'h1 && chkOn === 1'h1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            `CHK(wbDatO, e)
        end
        if (cycles > 20000) begin
            failCount++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(15600));
        repeat (4) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        rdChk(`CTRL_OFS, 32'h0);
        rdChk(`FAULT1_OFS, 32'h20);
        bus(8'h3c, 1'h1, 32'hffffffff);
        rdChk(8'h3c, 32'h0);
        hvHeadroomLow <= 1'h1;
        accOverIn <= 1'h1;
        accUnderIn <= 1'h1;
        flexPackFaultIn <= 1'h1;
        repeat (3) @(posedge clock);
        rdChk(`FAULT1_OFS, 32'h24);
        oversampleDone <= 1'h1;
        @(posedge clock);
        oversampleDone <= 1'h0;
        rdChk(`FAULT1_OFS, 32'h3c);
        foreach (oscSet[i]) begin
            oscKhz <= oscSet[i];
            oscKhzValid <= 1'h1;
            @(posedge clock);
            oscKhzValid <= 1'h0;
            rdChk(`SECOND_STATUS_REG_OFS, {26'h0, oscHit[i], 5'h0});
            bus(`SECOND_STATUS_REG_OFS, 1'h1, 32'h20);
        end
        $display("test flags done");
        // every selector code on both sides
        for (int a = 0; a <= 12; a++) begin
            b = (a == 12) ? 4'h0 : 4'(12 - a);
            cv = '0;
            cv.diagSelectorA = 4'(a);
            cv.diagSelectorB = b;
            slow <= 1'($urandom);
            wrCtrl();
            `CHK(dieTempMonitorEn, 1'(a != 1 && b != 4'h1))
            bus(`CMD_OFS, 1'h1, 32'h1);
            rdat = 32'h1;
            for (int n = 0; n < 500 && rdat[0] !== 1'h0; n++) bus(`CMD_OFS, 1'h0, 32'h0);
            if (a != 0) expA = resultOf(4'(a));
            if (b != 4'h0) expB = resultOf(b);
            rdChk(`RESULT_A_OFS, expA);
            rdChk(`RESULT_B_OFS, expB);
            if (a == 1 || b == 4'h1) `CHK(settle >= 779, 1'h1)
            if (a == 0) rdChk(`FAULT1_OFS, 32'h3d);
        end
        hvHeadroomLow <= 1'h0;
        accOverIn <= 1'h0;
        accUnderIn <= 1'h0;
        flexPackFaultIn <= 1'h0;
        bus(`FAULT1_OFS, 1'h1, 32'h7f);
        rdChk(`FAULT1_OFS, 32'h0);
        $display("test selectors done");
        // open test set up as the host must
        cv = '0;
        cv.scanConfigField = `SCAN_COMP;
        cv.openDiagSelect = 1'h1;
        wrCtrl();
        bus(`THRESH_OFS, 1'h1, 32'h100);
        mask = 14'($urandom);
        bus(`CELLCFG_OFS, 1'h1, {2'h0, mask, 16'h0008});
        @(posedge clock);
        `CHK(testCurrentEn, mask)
        expA = 32'h0;
        for (int i = 0; i < 14; i++) begin
            d = (i == 3) ? 10'h0 : 10'($urandom);
            compIn <= '{1'h1, 4'(i), d};
            if (i != 3 && d < 10'h100) expA[i] = 1'h1;
            @(posedge clock);
        end
        compIn <= '0;
        rdChk(`COMP_ALERT_OFS, expA);
        bus(`COMP_ALERT_OFS, 1'h1, 32'h3fff);
        for (int s = 4; s <= 7; s++) begin
            cv.scanConfigField = 3'(s);
            wrCtrl();
            mask = 14'($urandom) | 14'h1;
            balSwFault <= mask;
            balSwValid <= 1'h1;
            @(posedge clock);
            balSwValid <= 1'h0;
            rdChk(`BAL_ALERT_OFS, {18'h0, mask});
            rdChk(`FAULT1_OFS, 32'h2);
            bus(`BAL_ALERT_OFS, 1'h1, 32'h3fff);
            bus(`FAULT1_OFS, 1'h1, 32'h2);
        end
        $display("test scans done");
        cv = '0;
        cv.interfaceSelect = 1'h1;
        cv.alertShortTestEnable = 1'h1;
        for (int k = 0; k < 12; k++) begin
            cv.serialConfigMode = 2'(k / 3);
            cv.userAlertBit = 1'(k % 3 == 2);
            alertPresent <= 1'(k % 3 == 1);
            wrCtrl();
            `CHK(alertOutEn, 1'h1)
            `CHK(ctrlO, cv)
            `CHK(alert_output_pin, 1'(k % 3 == 0))
        end
        for (int k = 0; k < 3; k++) begin
            cv.interfaceSelect = 1'(k == 0);
            cv.alertShortTestEnable = 1'(k != 0);
            cv.spiDriveInitBit = 1'(k == 2);
            wrCtrl();
            `CHK(alertOutEn, 1'(k == 2))
        end
        `CHK(alert_output_pin, 1'h0)
        $display("test alert pin done");
        report_and_stop();
    end
endmodule
